/* verilog/sas_pkg.sv */
// ****************************************************************
// sequencer constants
// ****************************************************************
package sas_pkg;
   localparam int unsigned MAX_CHANNELS   = 8;               // channel index is three bits wide
   localparam int unsigned CHAN_IDX_W     = 3;
   localparam int unsigned RESULT_W       = 10;              // converter word width
   localparam int unsigned LRES_W         = 8;               // reduced resolution width
   localparam int unsigned DIVIDER_W      = 6;               // conversion clock divider field
   localparam int unsigned WARMUP_W       = 5;               // warm-up field
   localparam int unsigned SHOLD_W        = 4;               // sample-and-hold field
   localparam int unsigned TSEL_W         = 3;               // trigger source code
   localparam int unsigned TIMER_TRG_N    = 6;               // internal trigger lines 0..5
   localparam int unsigned PRESC_W        = 8;               // divider counter, up to 128
   localparam int unsigned TICK_W         = 9;               // phase counter, up to 256 ticks

   localparam logic [TSEL_W-1:0]   TRG_EXT_CODE  = 3'h6;     // external trigger pin
   localparam logic [TSEL_W-1:0]   TRG_LAST_INT  = 3'h5;     // highest internal trigger code
   localparam logic [TICK_W-1:0]   CONV_TICKS    = 9'h00A;   // conversion clock periods per word
   localparam int unsigned         WARMUP_SHIFT  = 3;        // warm-up unit of 8 periods
   localparam logic [PRESC_W-1:0]  PRESC_FACTOR  = 8'h02;    // conversion clock = source / 2(n+1)

   // sequencer states, one-hot
   typedef enum logic [3:0] {
      SAS_IDLE    = 4'b0001,
      SAS_WARMUP  = 4'b0010,
      SAS_SAMPLE  = 4'b0100,
      SAS_CONVERT = 4'b1000
   } sas_state_e;
endpackage : sas_pkg

/* verilog/sas_sar_adc_sequencer.sv */
// What this block does
// - conversion: sample-hold cycles then ten clocks
// - conversion clock spans source/2 to source/128
// - reset full resolution; low mode zeroes top
// - transfers 16-bit normally, 8-bit in low
// - result stored per channel and last
// - completion sets done, ready; ready edge requests
// - interrupt on done or ready, enable gated
// - channel result read clears its done
// - last result read clears ready, last done
// - unread channel result overwritten sets channel overrun
// - new result while ready sets global overrun
// - status read clears all overrun flags
// - start command write is software trigger
// - hardware trigger on rising edge of source
// - one start converts all enabled channels
// - software start still works with hardware
// - channels enabled and disabled by set-writes
// - transfer requests only for enabled channels
// - sleep: power up, warm up, power down
// - triggers during a sequence are ignored
// - disabling mid-conversion leaves results unspecified
// - conversion clock is source over 2(n+1)
// - warm-up lasts (n+1) times 8 periods
// - sample-hold lasts n+1 periods
// - source codes 0-5 internal, 6 pin, 7 reserved
`timescale 1ns/1ps
module sas_sar_adc_sequencer #(
   parameter int unsigned NCH = 8
) (
   input  wire logic                                    clk_i,
   input  wire logic                                    rst_i,
   input  wire logic                                    start_cmd_i,
   input  wire logic                                    hw_trigger_enable_i,
   input  wire logic [sas_pkg::TSEL_W-1:0]              trigger_source_select_i,
   input  wire logic [sas_pkg::TIMER_TRG_N-1:0]         timer_output_a_i,
   input  wire logic                                    ext_trigger_i,
   input  wire logic                                    low_resolution_select_i,
   input  wire logic                                    sleep_mode_i,
   input  wire logic [sas_pkg::DIVIDER_W-1:0]           adc_clock_divider_i,
   input  wire logic [sas_pkg::WARMUP_W-1:0]            warmup_time_field_i,
   input  wire logic [sas_pkg::SHOLD_W-1:0]             sample_hold_cycles_i,
   input  wire logic [NCH-1:0]                          channel_enable_wr_i,
   input  wire logic [NCH-1:0]                          channel_disable_wr_i,
   input  wire logic [NCH-1:0]                          channel_result_rd_i,
   input  wire logic                                    last_result_rd_i,
   input  wire logic                                    flag_status_rd_i,
   input  wire logic [NCH-1:0]                          done_int_enable_i,
   input  wire logic                                    ready_int_enable_i,
   input  wire logic [sas_pkg::RESULT_W-1:0]            analog_data_i,
   output logic [NCH-1:0]                               channel_status_o,
   output logic [NCH*sas_pkg::RESULT_W-1:0]             channel_result_o,
   output logic [sas_pkg::RESULT_W-1:0]                 last_result_value_o,
   output logic [sas_pkg::CHAN_IDX_W-1:0]               last_channel_o,
   output logic [NCH-1:0]                               channel_conversion_done_o,
   output logic [NCH-1:0]                               channel_overrun_flag_o,
   output logic                                         result_ready_flag_o,
   output logic                                         global_overrun_flag_o,
   output logic                                         irq_o,
   output logic                                         dma_req_o,
   output logic                                         dma_size16_o,
   output logic                                         analog_power_o,
   output logic                                         analog_clk_en_o,
   output logic                                         analog_sample_o,
   output logic [sas_pkg::CHAN_IDX_W-1:0]               analog_mux_sel_o,
   output logic                                         busy_o
);
   import sas_pkg::*;

   // elaboration check on channel count
   if (NCH < 1 || NCH > MAX_CHANNELS) begin : g_bad_nch
      $error("channel count out of range");
   end

   // ****************************************************************
   // functions
   // ****************************************************************
   // lowest enabled channel at or above a given index, with found flag
   function automatic logic [CHAN_IDX_W:0] find_chan(input logic [MAX_CHANNELS-1:0] mask,
                                                     input logic [CHAN_IDX_W:0] from);
      find_chan = '0;
      for (int i = MAX_CHANNELS - 1; i >= 0; i--) begin
         if (mask[i] && (i >= int'(from))) begin
            find_chan = {1'b1, CHAN_IDX_W'(i)};
         end
      end
   endfunction : find_chan
   // result formatting for the selected resolution
   function automatic logic [RESULT_W-1:0] fmt(input logic [RESULT_W-1:0] v, input logic low);
      fmt = low ? {{(RESULT_W-LRES_W){1'b0}}, v[RESULT_W-1 -: LRES_W]} : v;
   endfunction : fmt

   // ****************************************************************
   // state
   // ****************************************************************
   sas_state_e               state_ff, nxt_state;
   logic [PRESC_W-1:0]       presc_ff;
   logic [TICK_W-1:0]        tick_cnt_ff;
   logic [CHAN_IDX_W-1:0]    cur_ch_ff;
   logic [NCH-1:0]           chan_en_ff;
   logic [NCH-1:0]           done_ff;
   logic [NCH-1:0]           ovr_ff;
   logic                     ready_ff;
   logic                     govr_ff;
   logic                     power_ff;
   logic                     dma_req_ff;
   logic [RESULT_W-1:0]      result_ff [NCH];
   logic [RESULT_W-1:0]      last_ff;
   logic [CHAN_IDX_W-1:0]    last_ch_ff;
   logic [TIMER_TRG_N:0]     trg_meta_ff;
   logic [TIMER_TRG_N:0]     trg_sync_ff;
   logic                     trg_prev_ff;
   logic                     tick;
   logic                     phase_end;
   logic                     trg_sel;
   logic                     start;
   logic                     complete;
   logic [CHAN_IDX_W:0]      first_ch;
   logic [CHAN_IDX_W:0]      next_ch;
   logic [PRESC_W-1:0]       presc_top;
   logic [MAX_CHANNELS-1:0]  en_mask;

   // ****************************************************************
   // conversion clock divider
   // ****************************************************************
   // period of 2(n+1) source cycles, held at zero while idle for a fixed phase
   assign presc_top = PRESC_W'(PRESC_FACTOR * (PRESC_W'(adc_clock_divider_i) + 8'h01) - 8'h01);
   assign tick      = (presc_ff == presc_top);
   always_ff @(posedge clk_i) begin
      if (rst_i || state_ff == SAS_IDLE || tick) begin
         presc_ff <= '0;
      end else begin
         presc_ff <= presc_ff + 8'h01;
      end
   end

   // ****************************************************************
   // trigger selection
   // ****************************************************************
   // two-stage synchroniser on all hardware trigger lines, then the edge detect delay
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trg_meta_ff <= '0;
         trg_sync_ff <= '0;
         trg_prev_ff <= 1'b0;
      end else begin
         trg_meta_ff <= {ext_trigger_i, timer_output_a_i};
         trg_sync_ff <= trg_meta_ff;
         trg_prev_ff <= trg_sel;
      end
   end

   // source decode; reserved code selects nothing
   assign trg_sel = (trigger_source_select_i == TRG_EXT_CODE) ? trg_sync_ff[TIMER_TRG_N] :
                    (trigger_source_select_i <= TRG_LAST_INT) ? trg_sync_ff[trigger_source_select_i] : 1'b0;
   // either source starts; only honoured while idle
   assign start = start_cmd_i || (hw_trigger_enable_i && trg_sel && !trg_prev_ff);

   // ****************************************************************
   // sequencer
   // ****************************************************************
   assign en_mask   = MAX_CHANNELS'(chan_en_ff);
   assign first_ch  = find_chan(en_mask, '0);
   assign next_ch   = find_chan(en_mask, {1'b0, cur_ch_ff} + 4'h1);
   assign phase_end = tick && (tick_cnt_ff == '0);
   assign complete  = (state_ff == SAS_CONVERT) && phase_end;
   // next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SAS_IDLE: begin
            if (start && first_ch[CHAN_IDX_W]) begin
               nxt_state = power_ff ? SAS_SAMPLE : SAS_WARMUP;
            end
         end
         SAS_WARMUP: begin
            if (phase_end) begin
               nxt_state = first_ch[CHAN_IDX_W] ? SAS_SAMPLE : SAS_IDLE;
            end
         end
         SAS_SAMPLE: begin
            if (phase_end) begin
               nxt_state = SAS_CONVERT;
            end
         end
         SAS_CONVERT: begin
            if (phase_end) begin
               nxt_state = next_ch[CHAN_IDX_W] ? SAS_SAMPLE : SAS_IDLE;
            end
         end
         default: nxt_state = SAS_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= SAS_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // phase length counter in conversion clock periods
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_cnt_ff <= '0;
      end else if (state_ff != nxt_state || (state_ff == SAS_CONVERT && phase_end)) begin
         case (nxt_state)
            SAS_WARMUP:  tick_cnt_ff <= TICK_W'(({4'h0, warmup_time_field_i} + 9'h001) << WARMUP_SHIFT) - 9'h001;
            SAS_SAMPLE:  tick_cnt_ff <= TICK_W'(sample_hold_cycles_i);
            SAS_CONVERT: tick_cnt_ff <= CONV_TICKS - 9'h001;
            default:     tick_cnt_ff <= '0;
         endcase
      end else if (tick) begin
         tick_cnt_ff <= tick_cnt_ff - 9'h001;
      end
   end

   // channel pointer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur_ch_ff <= '0;
      end else if (state_ff == SAS_IDLE || state_ff == SAS_WARMUP) begin
         cur_ch_ff <= first_ch[CHAN_IDX_W-1:0];
      end else if (complete) begin
         cur_ch_ff <= next_ch[CHAN_IDX_W-1:0];
      end
   end

   // analog cell power; off after a sequence only in sleep mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         power_ff <= 1'b0;
      end else if (state_ff == SAS_WARMUP) begin
         power_ff <= 1'b1;
      end else if (state_ff == SAS_IDLE && sleep_mode_i) begin
         power_ff <= 1'b0;
      end
   end

   // ****************************************************************
   // channel enables
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chan_en_ff <= '0;
      end else begin
         chan_en_ff <= (chan_en_ff | channel_enable_wr_i) & ~channel_disable_wr_i;
      end
   end

   // ****************************************************************
   // results and flags
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_ff    <= '0;
         last_ch_ff <= '0;
         for (int i = 0; i < NCH; i++) begin
            result_ff[i] <= '0;
         end
      end else if (complete) begin
         result_ff[cur_ch_ff] <= fmt(analog_data_i, low_resolution_select_i);
         last_ff              <= fmt(analog_data_i, low_resolution_select_i);
         last_ch_ff           <= cur_ch_ff;
      end
   end

   // per-channel done and overrun; a set wins over a clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_ff <= '0;
         ovr_ff  <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (complete && cur_ch_ff == CHAN_IDX_W'(i)) begin
               done_ff[i] <= 1'b1;
               ovr_ff[i]  <= ovr_ff[i] || done_ff[i];
            end else begin
               if (channel_result_rd_i[i] || (last_result_rd_i && last_ch_ff == CHAN_IDX_W'(i))) begin
                  done_ff[i] <= 1'b0;
               end
               if (flag_status_rd_i) begin
                  ovr_ff[i] <= 1'b0;
               end
            end
         end
      end
   end

   // shared ready and global overrun
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ready_ff <= 1'b0;
         govr_ff  <= 1'b0;
      end else if (complete) begin
         ready_ff <= 1'b1;
         govr_ff  <= govr_ff || ready_ff;
      end else begin
         if (last_result_rd_i) begin
            ready_ff <= 1'b0;
         end
         if (flag_status_rd_i) begin
            govr_ff <= 1'b0;
         end
      end
   end

   // transfer request on rising ready, for enabled channels only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dma_req_ff <= 1'b0;
      end else begin
         dma_req_ff <= complete && !ready_ff && chan_en_ff[cur_ch_ff];
      end
   end
   // ****************************************************************
   // outputs
   // ****************************************************************
   for (genvar g = 0; g < NCH; g++) begin : g_res
      assign channel_result_o[g*RESULT_W +: RESULT_W] = result_ff[g];
   end

   assign channel_status_o          = chan_en_ff;
   assign last_result_value_o       = last_ff;
   assign last_channel_o            = last_ch_ff;
   assign channel_conversion_done_o = done_ff;
   assign channel_overrun_flag_o    = ovr_ff;
   assign result_ready_flag_o       = ready_ff;
   assign global_overrun_flag_o     = govr_ff;
   assign irq_o                     = |(done_ff & done_int_enable_i) || (ready_ff && ready_int_enable_i);
   assign dma_req_o                 = dma_req_ff;
   assign dma_size16_o              = !low_resolution_select_i;
   assign analog_power_o            = power_ff || (state_ff != SAS_IDLE);
   assign analog_clk_en_o           = tick;
   assign analog_sample_o           = (state_ff == SAS_SAMPLE);
   assign analog_mux_sel_o          = cur_ch_ff;
   assign busy_o                    = (state_ff != SAS_IDLE);
endmodule : sas_sar_adc_sequencer

/* verif/sas_model.sv */
`timescale 1ns/1ps
// ****
// analog cell and input multiplexer stand-in
// ****
module sas_analog_model (
   input  wire logic       clk_i,
   input  wire logic       power_i,
   input  wire logic       sample_i,
   input  wire logic [2:0] mux_sel_i,
   input  wire logic [6:0] tag_i,
   output logic      [9:0] data_o
);
   logic       held_ff  = 1'b0;    // a converted word is on the data lines
   logic       smp_q_ff = 1'b0;
   logic [2:0] ch_ff    = 3'h0;
   logic [9:0] junk_ff  = 10'h2A5; // changes every cycle while no word is valid
   // the word is valid from the end of sampling until the next sample or power-down
   always @(posedge clk_i) begin
      smp_q_ff <= sample_i;
      junk_ff  <= junk_ff + 10'h16B;
      held_ff  <= power_i && !sample_i && (held_ff || smp_q_ff);
      if (sample_i) begin
         ch_ff <= mux_sel_i;
      end
   end
   assign data_o = held_ff ? {tag_i, ch_ff} : junk_ff;
endmodule : sas_analog_model

/* verif/sas_chk_asserts.sv */
`timescale 1ns/1ps
// ****
// port checker
// ****
module sas_chk #(
   parameter int unsigned NCH = 8
) (
   input wire logic                          clk_i,
   input wire logic                          rst_i,
   input wire logic                          low_resolution_select_i,
   input wire logic                          sleep_mode_i,
   input wire logic [sas_pkg::DIVIDER_W-1:0] adc_clock_divider_i,
   input wire logic [sas_pkg::SHOLD_W-1:0]   sample_hold_cycles_i,
   input wire logic [NCH-1:0]                channel_result_rd_i,
   input wire logic                          last_result_rd_i,
   input wire logic                          flag_status_rd_i,
   input wire logic [NCH-1:0]                done_int_enable_i,
   input wire logic                          ready_int_enable_i,
   input wire logic [NCH-1:0]                channel_conversion_done_o,
   input wire logic [NCH-1:0]                channel_overrun_flag_o,
   input wire logic                          result_ready_flag_o,
   input wire logic                          global_overrun_flag_o,
   input wire logic                          irq_o,
   input wire logic                          dma_req_o,
   input wire logic                          dma_size16_o,
   input wire logic                          analog_power_o,
   input wire logic                          analog_sample_o,
   input wire logic                          busy_o
);
   import sas_pkg::*;
   logic [11:0] period_w; // conversion clock period in source cycles
   logic [11:0] shold_ff; // cycles spent sampling
   logic [11:0] conv_ff;  // cycles since sampling ended
   assign period_w = {5'h00, adc_clock_divider_i, 1'b0} + 12'h002;
   // phase length counters
   always_ff @(posedge clk_i) begin
      if (rst_i || !analog_sample_o) begin
         shold_ff <= 12'h000;
      end else begin
         shold_ff <= shold_ff + 12'h001;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i || analog_sample_o) begin
         conv_ff <= 12'h000;
      end else if (conv_ff != 12'hFFF) begin
         conv_ff <= conv_ff + 12'h001;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_shold_len: assert property ($fell(analog_sample_o) |->
      shold_ff == ({8'h00, sample_hold_cycles_i} + 12'h001) * period_w) else $error("sample phase length wrong");
   a_conv_len: assert property ($rose(result_ready_flag_o) |->
      conv_ff == {3'h0, CONV_TICKS} * period_w) else $error("conversion phase length wrong");
   a_dma_width: assert property (dma_size16_o == !low_resolution_select_i)
      else $error("transfer size wrong");
   a_dma_rise: assert property (dma_req_o == $rose(result_ready_flag_o))
      else $error("transfer request not tied to ready rise");
   a_irq_gate: assert property (irq_o == ((|(channel_conversion_done_o & done_int_enable_i)) ||
      (result_ready_flag_o && ready_int_enable_i))) else $error("interrupt level wrong");
   a_chan_clear: assert property ((|channel_result_rd_i) && !busy_o |=>
      (channel_conversion_done_o & $past(channel_result_rd_i)) == '0) else $error("done not cleared");
   a_last_clear: assert property (last_result_rd_i && !busy_o |=> !result_ready_flag_o)
      else $error("ready not cleared");
   a_ovr_clear: assert property (flag_status_rd_i && !busy_o |=>
      !(|channel_overrun_flag_o) && !global_overrun_flag_o) else $error("overruns not cleared");
   a_govr_cause: assert property ($rose(global_overrun_flag_o) |-> $past(result_ready_flag_o))
      else $error("global overrun without ready");
   a_ovr_cause: assert property ((channel_overrun_flag_o & ~$past(channel_overrun_flag_o) &
      ~$past(channel_conversion_done_o)) == '0) else $error("overrun without unread result");
   a_sleep_off: assert property ($fell(busy_o) && sleep_mode_i |=> !analog_power_o || busy_o)
      else $error("cell not powered down");
   c_govr: cover property ($rose(global_overrun_flag_o));
   c_dma8: cover property (dma_req_o && !dma_size16_o);
   c_power: cover property ($fell(analog_power_o));
endmodule : sas_chk

bind sas_sar_adc_sequencer sas_chk #(.NCH(NCH)) chk_u (
   .clk_i, .rst_i, .low_resolution_select_i, .sleep_mode_i, .adc_clock_divider_i, .sample_hold_cycles_i,
   .channel_result_rd_i, .last_result_rd_i, .flag_status_rd_i, .done_int_enable_i, .ready_int_enable_i,
   .channel_conversion_done_o, .channel_overrun_flag_o, .result_ready_flag_o, .global_overrun_flag_o, .irq_o,
   .dma_req_o, .dma_size16_o, .analog_power_o, .analog_sample_o, .busy_o);

/* verif/sas_testbench.sv */
`timescale 1ns/1ps
// ****
// sequencer testbench
// ****
module testbench;
   logic        clk_i = 1'b0, rst_i = 1'b1, start_cmd_i = 1'b0, hw_trigger_enable_i = 1'b0, ext_trigger_i = 1'b0;
   logic        low_resolution_select_i = 1'b0, sleep_mode_i = 1'b1, last_result_rd_i = 1'b0, flag_status_rd_i = 1'b0;
   logic        ready_int_enable_i = 1'b1, irq_o, dma_req_o, dma_size16_o, analog_power_o, analog_clk_en_o;
   logic        result_ready_flag_o, global_overrun_flag_o, analog_sample_o, busy_o;
   logic [2:0]  trigger_source_select_i = 3'h0, last_channel_o, analog_mux_sel_o;
   logic [5:0]  timer_output_a_i = 6'h00, adc_clock_divider_i = 6'h00;
   logic [4:0]  warmup_time_field_i = 5'h00;
   logic [3:0]  sample_hold_cycles_i = 4'h1;
   logic [7:0]  channel_enable_wr_i = 8'h00, channel_disable_wr_i = 8'h00, channel_result_rd_i = 8'h00;
   logic [7:0]  done_int_enable_i = 8'hFF, channel_status_o, channel_conversion_done_o, channel_overrun_flag_o;
   logic [9:0]  analog_data_i, last_result_value_o;
   logic [79:0] channel_result_o;
   logic [6:0]  code_r = 7'h15;  // upper bits of the word the cell returns
   int          error_cnt = 0, tests_run = 0, dma_cnt = 0, clk_cnt = 0, n;

   sas_sar_adc_sequencer #(.NCH(8)) dut_u (
      .clk_i, .rst_i, .start_cmd_i, .hw_trigger_enable_i, .trigger_source_select_i, .timer_output_a_i,
      .ext_trigger_i, .low_resolution_select_i, .sleep_mode_i, .adc_clock_divider_i, .warmup_time_field_i,
      .sample_hold_cycles_i, .channel_enable_wr_i, .channel_disable_wr_i, .channel_result_rd_i, .last_result_rd_i,
      .flag_status_rd_i, .done_int_enable_i, .ready_int_enable_i, .analog_data_i, .channel_status_o,
      .channel_result_o, .last_result_value_o, .last_channel_o, .channel_conversion_done_o, .channel_overrun_flag_o,
      .result_ready_flag_o, .global_overrun_flag_o, .irq_o, .dma_req_o, .dma_size16_o, .analog_power_o,
      .analog_clk_en_o, .analog_sample_o, .analog_mux_sel_o, .busy_o);
   sas_analog_model cell_u (.clk_i, .power_i(analog_power_o), .sample_i(analog_sample_o),
      .mux_sel_i(analog_mux_sel_o), .tag_i(code_r), .data_o(analog_data_i));

   // clock, transfer request and conversion clock counters
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) if (dma_req_o) dma_cnt <= dma_cnt + 1;
   always @(posedge clk_i) if (analog_clk_en_o) clk_cnt <= clk_cnt + 1;

   function automatic logic [9:0] word(input logic [2:0] ch);
      word = low_resolution_select_i ? ({code_r, ch} >> 2) : {code_r, ch};
   endfunction : word

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk

   task automatic end_of_test;
      if (error_cnt == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   // one-cycle access strobe: 0 start, 1 enable, 2 disable, 3 channel read, 4 last read, 5 status read
   task automatic wr(input int k, input logic [7:0] m);
      @(posedge clk_i);
      case (k)
         0: start_cmd_i <= 1'b1;
         1: channel_enable_wr_i <= m;
         2: channel_disable_wr_i <= m;
         3: channel_result_rd_i <= m;
         4: last_result_rd_i <= 1'b1;
         default: flag_status_rd_i <= 1'b1;
      endcase
      @(posedge clk_i);
      {start_cmd_i, last_result_rd_i, flag_status_rd_i} <= 3'h0;
      {channel_enable_wr_i, channel_disable_wr_i, channel_result_rd_i} <= 24'h000000;
      @(negedge clk_i);
   endtask : wr

   task automatic wait_busy(input logic lvl);
      int t;
      t = 0;
      while (busy_o !== lvl && t < 6000) begin
         @(negedge clk_i);
         t++;
      end
      if (busy_o !== lvl) begin
         chk(busy_o, lvl);
         end_of_test;
      end
   endtask : wait_busy

   // main sequence
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk({channel_status_o, channel_conversion_done_o, result_ready_flag_o, global_overrun_flag_o}, 32'h0);
      chk({last_result_value_o, dma_size16_o}, 32'h1);
      wr(1, 8'h0A);
      chk(channel_status_o, 32'h0A);
      wr(0, 8'h00);
      wait_busy(1'b1);
      n = 0;
      while (!analog_sample_o && n < 100) begin
         @(negedge clk_i);
         n++;
      end
      chk(n, 32'h10);
      wait_busy(1'b0);
      chk({channel_result_o[39:30], channel_result_o[19:10]}, {word(3), word(1)});
      chk({channel_result_o[9:0], last_result_value_o, last_channel_o}, {word(3), 3'h3});
      chk({channel_conversion_done_o, result_ready_flag_o, global_overrun_flag_o, 16'(dma_cnt)}, 32'h2B0001);
      chk(irq_o, 32'h1);
      chk(clk_cnt, 32'h20);
      repeat (2) @(negedge clk_i);
      chk(analog_power_o, 32'h0);
      code_r = 7'h2C;
      wr(0, 8'h00);
      wait_busy(1'b1);
      wr(0, 8'h00);
      wait_busy(1'b0);
      repeat (30) @(negedge clk_i);
      chk({busy_o, channel_overrun_flag_o, channel_result_o[39:30]}, {1'b0, 8'h0A, word(3)});
      wr(3, 8'h02);
      chk(channel_conversion_done_o, 32'h08);
      wr(4, 8'h00);
      chk({channel_conversion_done_o, result_ready_flag_o}, 32'h0);
      wr(5, 8'h00);
      chk({channel_overrun_flag_o, global_overrun_flag_o}, 32'h0);
      wr(2, 8'h02);
      chk(channel_status_o, 32'h08);
      @(posedge clk_i);
      low_resolution_select_i <= 1'b1;
      hw_trigger_enable_i <= 1'b1;
      @(negedge clk_i);
      chk(dma_size16_o, 32'h0);
      for (int c = 0; c < 8; c++) begin
         @(posedge clk_i);
         trigger_source_select_i <= 3'(c);
         code_r <= 7'(c * 9);
         repeat (3) @(posedge clk_i);
         timer_output_a_i <= (c == 7) ? 6'h3F : (6'h01 << c);
         ext_trigger_i <= (c >= 6);
         if (c < 7) begin
            wait_busy(1'b1);
            wait_busy(1'b0);
            chk(last_result_value_o, word(3));
            wr(4, 8'h00);
         end else begin
            repeat (30) @(negedge clk_i);
            chk(busy_o, 32'h0);
         end
         @(posedge clk_i);
         timer_output_a_i <= 6'h00;
         ext_trigger_i <= 1'b0;
      end
      chk({channel_result_o[19:10], 16'(dma_cnt)}, {10'h161, 16'h0008});
      @(posedge clk_i);
      adc_clock_divider_i <= 6'h3F;
      sample_hold_cycles_i <= 4'hF;
      done_int_enable_i <= 8'h00;
      ready_int_enable_i <= 1'b0;
      wr(0, 8'h00);
      wait_busy(1'b1);
      wait_busy(1'b0);
      chk({last_result_value_o, irq_o}, {word(3), 1'b0});
      end_of_test;
   end
endmodule : testbench
